// file: design/adcstc_consts.svh
`ifndef ADCSTC_CONSTS_SVH
`define ADCSTC_CONSTS_SVH

// register byte offsets
// eight address bits: the scan register sits above 0x3F
`define ADCSTC_OFF_HIGH      8'h14
`define ADCSTC_OFF_LOW       8'h18
`define ADCSTC_OFF_TRIG      8'h1C
`define ADCSTC_OFF_SCAN      8'h58
`define ADCSTC_OFF_CTRL      8'h00
`define ADCSTC_OFF_STAT      8'h04
`define ADCSTC_OFF_IRQ_FLAG  8'h08
`define ADCSTC_OFF_IRQ_CLR   8'h0C
`define ADCSTC_OFF_IRQ_EN    8'h10
`define ADCSTC_OFF_RESULT    8'h20

// reset values
`define ADCSTC_RST_HIGH      32'h0000_0FFF
`define ADCSTC_RST_LOW       32'h0000_0000
`define ADCSTC_RST_TRIG      32'h0000_0000
`define ADCSTC_RST_SCAN      32'h0000_0000

// field layout
`define ADCSTC_SCAN_REPEAT   16
`define ADCSTC_SCAN_MASK     32'h0001_FFFF
`define ADCSTC_THR_MASK      32'h0000_0FFF
`define ADCSTC_TRIG_MASK     32'h01F8_FFEF
`define ADCSTC_CHAN_SUPPLY   13
`define ADCSTC_CHAN_TEMP     14
`define ADCSTC_CHAN_CORE     15

// interrupt status bits
`define ADCSTC_IRQ_CONV      0
`define ADCSTC_IRQ_SCAN_DONE 1
`define ADCSTC_IRQ_LOWER     2
`define ADCSTC_IRQ_UPPER     3
`define ADCSTC_IRQ_INTERVAL  4
`define ADCSTC_IRQ_W         5

`endif

// file: design/adcstc_pkg.sv
package adcstc_pkg;
	// scan sequencer states, one-hot
	typedef enum logic [2:0] {
		ADCSTC_IDLE = 3'h1,
		ADCSTC_CONV = 3'h2,
		ADCSTC_NEXT = 3'h4
	} adcstc_state_t;
endpackage

// file: design/adcstc_top.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "adcstc_consts.svh"
// Notes on behaviour
// - repeat clear: scan rounds until start cleared
// - repeat set: one pass, then stop
// - enable bit n includes input n
// - bits 13-15: supply third, temp, core
// - high limit 12 bits, resets all ones
// - low limit 12 bits, resets zero
// - bits 19-22, 24 gate GPIO A-D, F; the trigger mask also passes bit 23
// - bits 8-15 gate serial, SPI, I2C, DMA
// - bit 0 advanced, 1-3 general, 5-7 basic
// - interval flag: low <= result < high
// - upper [high,4096), lower [0,low)
module adcstc_top (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	input  wire logic [31:0] trigger_events,
	input  wire logic        conv_done,
	input  wire logic [11:0] conv_result,
	output logic             conv_start,
	output logic      [3:0]  conv_channel,
	output logic             scan_busy,
	output logic             irq
);
	// software registers
	logic [11:0] watchdog_high_limit, next_high;
	logic [11:0] watchdog_low_limit, next_low;
	logic [31:0] trigger_source_mask, next_trig;
	logic [16:0] scan_channel_config, next_scan;
	logic        start_ctrl, next_start;      // run control bit
	logic        trig_mode, next_trig_mode;   // 1: wait for trigger
	logic [`ADCSTC_IRQ_W-1:0] irq_flag, next_irq_flag;
	logic [`ADCSTC_IRQ_W-1:0] irq_en, next_irq_en;
	logic [11:0] last_result, next_result;    // most recent result
	logic [31:0] next_rdata;
	// sequencer state
	adcstc_pkg::adcstc_state_t state, next_state;
	logic [3:0]  chan, next_chan;             // channel in progress
	logic        next_conv_start;
	logic        next_irq;
	// synchronised trigger lines from other blocks' domain
	logic [31:0] trig_s1, trig_s2;
	// combinational helpers
	logic        trigger_hit;
	logic        win_in, win_up, win_lo;
	logic [3:0]  nxt_en_chan;
	logic        have_next;

	// first enabled channel at or after "from", wrapping is not done
	function automatic logic [4:0] adcstc_find(input logic [15:0] en,
		input logic [4:0] from);
		logic [4:0] r;
		r = 5'h10;
		for (int i = 15; i >= 0; i--) begin
			if (en[i] && (5'(i) >= from))
				r = 5'(i);
		end
		return r;
	endfunction

	// interrupt lines arrive from peripheral logic; two stages first
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			trig_s1 <= 32'h0000_0000;
			trig_s2 <= 32'h0000_0000;
		end else if (clk_en) begin
			trig_s1 <= trigger_events;
			trig_s2 <= trig_s1;
		end
	end

	adcstc_trigger u_trig (
		.trigger_events      (trig_s2),
		.trigger_source_mask (trigger_source_mask),
		.trigger_hit         (trigger_hit)
	);

	// window compare on each new result
	adcstc_window u_win (
		.result                 (conv_result),
		.watchdog_high_limit    (watchdog_high_limit),
		.watchdog_low_limit     (watchdog_low_limit),
		.watchdog_interval_flag (win_in),
		.watchdog_upper_flag    (win_up),
		.watchdog_lower_flag    (win_lo)
	);

	// next enabled channel after the current one
	always_comb begin
		logic [4:0] f;
		f = 5'h10;
		f = adcstc_find(scan_channel_config[15:0], {1'b0, chan} + 5'h01);
		have_next   = ~f[4];
		nxt_en_chan = f[3:0];
	end

	// register writes, sequencer and flags
	always_comb begin
		logic [4:0] first;
		logic [`ADCSTC_IRQ_W-1:0] ev;
		first           = adcstc_find(scan_channel_config[15:0], 5'h00);
		ev              = '0;
		next_high       = watchdog_high_limit;
		next_low        = watchdog_low_limit;
		next_trig       = trigger_source_mask;
		next_scan       = scan_channel_config;
		next_start      = start_ctrl;
		next_trig_mode  = trig_mode;
		next_irq_en     = irq_en;
		next_result     = last_result;
		next_state      = state;
		next_chan       = chan;
		next_conv_start = 1'b0;
		// writes; reserved bits are stored as zero
		if (reg_write) begin
			case (reg_addr)
				`ADCSTC_OFF_HIGH: next_high = reg_wdata[11:0];
				`ADCSTC_OFF_LOW:  next_low = reg_wdata[11:0];
				`ADCSTC_OFF_TRIG: next_trig = reg_wdata & `ADCSTC_TRIG_MASK;
				`ADCSTC_OFF_SCAN: next_scan = reg_wdata[16:0];
				`ADCSTC_OFF_CTRL: begin
					next_start     = reg_wdata[0];
					next_trig_mode = reg_wdata[1];
				end
				`ADCSTC_OFF_IRQ_EN: next_irq_en = reg_wdata[`ADCSTC_IRQ_W-1:0];
				default: ;
			endcase
		end
		// sequencer
		case (state)
			adcstc_pkg::ADCSTC_IDLE: begin
				// no channel enabled means nothing to scan
				if (start_ctrl && !first[4] && (!trig_mode || trigger_hit)) begin
					next_chan       = first[3:0];
					next_conv_start = 1'b1;
					next_state      = adcstc_pkg::ADCSTC_CONV;
				end
			end
			adcstc_pkg::ADCSTC_CONV: begin
				if (conv_done) begin
					next_result = conv_result;
					ev[`ADCSTC_IRQ_CONV]     = 1'b1;
					ev[`ADCSTC_IRQ_LOWER]    = win_lo;
					ev[`ADCSTC_IRQ_UPPER]    = win_up;
					ev[`ADCSTC_IRQ_INTERVAL] = win_in;
					next_state = adcstc_pkg::ADCSTC_NEXT;
				end
			end
			adcstc_pkg::ADCSTC_NEXT: begin
				if (!start_ctrl) begin
					// software stop ends the scan
					next_state = adcstc_pkg::ADCSTC_IDLE;
				end else if (have_next) begin
					next_chan       = nxt_en_chan;
					next_conv_start = 1'b1;
					next_state      = adcstc_pkg::ADCSTC_CONV;
				end else begin
					ev[`ADCSTC_IRQ_SCAN_DONE] = 1'b1;
					next_state = adcstc_pkg::ADCSTC_IDLE;
					if (scan_channel_config[`ADCSTC_SCAN_REPEAT]) begin
						next_start = 1'b0;
					end else if (!first[4]) begin
						next_chan       = first[3:0];
						next_conv_start = 1'b1;
						next_state      = adcstc_pkg::ADCSTC_CONV;
					end
				end
			end
			default: next_state = adcstc_pkg::ADCSTC_IDLE;
		endcase
		// sticky flags; a new event wins over a clear in the same cycle
		next_irq_flag = irq_flag;
		if (reg_write && reg_addr == `ADCSTC_OFF_IRQ_CLR)
			next_irq_flag = irq_flag & ~reg_wdata[`ADCSTC_IRQ_W-1:0];
		next_irq_flag = next_irq_flag | ev;
		next_irq      = |(next_irq_flag & next_irq_en);
	end

	// read mux, data stands the cycle after the strobe only
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (reg_read) begin
			case (reg_addr)
				`ADCSTC_OFF_HIGH:     next_rdata = {20'h0, watchdog_high_limit};
				`ADCSTC_OFF_LOW:      next_rdata = {20'h0, watchdog_low_limit};
				`ADCSTC_OFF_TRIG:     next_rdata = trigger_source_mask;
				`ADCSTC_OFF_SCAN:     next_rdata = {15'h0, scan_channel_config};
				`ADCSTC_OFF_CTRL:     next_rdata = {30'h0, trig_mode, start_ctrl};
				`ADCSTC_OFF_STAT:     next_rdata = {24'h0, 3'h0, chan,
					scan_busy};
				`ADCSTC_OFF_IRQ_FLAG: next_rdata = {27'h0, irq_flag};
				`ADCSTC_OFF_IRQ_EN:   next_rdata = {27'h0, irq_en};
				`ADCSTC_OFF_RESULT:   next_rdata = {20'h0, last_result};
				default:              next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// all state registers, frozen while clk_en is low
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			watchdog_high_limit <= 12'hFFF;
			watchdog_low_limit  <= 12'h000;
			trigger_source_mask <= `ADCSTC_RST_TRIG;
			scan_channel_config <= 17'h0_0000;
			start_ctrl          <= 1'b0;
			trig_mode           <= 1'b0;
			irq_flag            <= '0;
			irq_en              <= '0;
			last_result         <= 12'h000;
			state               <= adcstc_pkg::ADCSTC_IDLE;
			chan                <= 4'h0;
			conv_start          <= 1'b0;
			conv_channel        <= 4'h0;
			scan_busy           <= 1'b0;
			irq                 <= 1'b0;
			reg_rdata           <= 32'h0000_0000;
		end else if (clk_en) begin
			watchdog_high_limit <= next_high;
			watchdog_low_limit  <= next_low;
			trigger_source_mask <= next_trig;
			scan_channel_config <= next_scan;
			start_ctrl          <= next_start;
			trig_mode           <= next_trig_mode;
			irq_flag            <= next_irq_flag;
			irq_en              <= next_irq_en;
			last_result         <= next_result;
			state               <= next_state;
			chan                <= next_chan;
			// channel number is the enable bit index
			conv_start          <= next_conv_start;
			conv_channel        <= next_chan;
			scan_busy           <= (next_state != adcstc_pkg::ADCSTC_IDLE);
			irq                 <= next_irq;
			reg_rdata           <= next_rdata;
		end
	end
endmodule

// file: design/adcstc_trigger.sv
`timescale 1ns/1ps
`include "adcstc_consts.svh"
// gates peripheral interrupt lines by the trigger mask and merges them
module adcstc_trigger (
	input  wire logic [31:0] trigger_events,
	input  wire logic [31:0] trigger_source_mask,
	output logic             trigger_hit
);
	logic [31:0] gated; // per-source enabled events
	// positions that carry a real source
	localparam logic [31:0] TRIG_DEFINED = `ADCSTC_TRIG_MASK;

	// reserved positions are masked off even if software sets them
	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : gen_gate
			assign gated[g] = trigger_events[g] & trigger_source_mask[g]
				& TRIG_DEFINED[g];
		end
	endgenerate

	assign trigger_hit = |gated;
endmodule

// file: design/adcstc_window.sv
`timescale 1ns/1ps
// watchdog comparison of a 12-bit result against both limits
module adcstc_window (
	input  wire logic [11:0] result,
	input  wire logic [11:0] watchdog_high_limit,
	input  wire logic [11:0] watchdog_low_limit,
	output logic             watchdog_interval_flag,
	output logic             watchdog_upper_flag,
	output logic             watchdog_lower_flag
);
	// half-open intervals; with low above high the interval is empty
	always_comb begin
		watchdog_upper_flag    = (result >= watchdog_high_limit);
		watchdog_lower_flag    = (result < watchdog_low_limit);
		watchdog_interval_flag = (result >= watchdog_low_limit) &&
			(result < watchdog_high_limit);
	end
endmodule

// file: tb/adcstc_asserts.sv
`timescale 1ns/1ps
`include "adcstc_consts.svh"
// port-level checks of the register port and the scan handshake
module adcstc_asserts (
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic        conv_start,
	input wire logic        conv_done,
	input wire logic        scan_busy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// one read strobe aimed at a given offset
	sequence s_rd(logic [7:0] off);
		reg_read && reg_addr == off;
	endsequence
	high_rsv_a: assert property (s_rd(`ADCSTC_OFF_HIGH) |=>
		reg_rdata[31:12] == 20'h0) else $error("high limit reserved bits");
	low_rsv_a: assert property (s_rd(`ADCSTC_OFF_LOW) |=>
		reg_rdata[31:12] == 20'h0) else $error("low limit reserved bits");
	trig_rsv_a: assert property (s_rd(`ADCSTC_OFF_TRIG) |=>
		(reg_rdata & ~`ADCSTC_TRIG_MASK) == 0) else $error("trigger rsv");
	scan_rsv_a: assert property (s_rd(`ADCSTC_OFF_SCAN) |=>
		(reg_rdata & ~`ADCSTC_SCAN_MASK) == 0) else $error("scan rsv");
	unmapped_zero_a: assert property (s_rd(8'h3C) |=>
		reg_rdata == 32'h0) else $error("unmapped read not zero");
	idle_rdata_a: assert property (!reg_read |=>
		reg_rdata == 32'h0) else $error("read data without strobe");
	start_pulse_a: assert property (conv_start |=>
		!conv_start) else $error("start pulse longer than one cycle");
	start_busy_a: assert property (conv_start |->
		scan_busy) else $error("start without busy");
	// after a result the scan moves on or goes idle in bounded time
	done_next_a: assert property (conv_done |->
		##[1:4] (conv_start || !scan_busy)) else $error("scan stalled");
endmodule
bind adcstc_top adcstc_asserts i_adcstc_asserts (.*);

// file: tb/adcstc_conv_model.sv
`timescale 1ns/1ps
// converter stand-in: answers each start four cycles later
module adcstc_conv_model (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        conv_start,
	input  wire logic [11:0] level,
	output logic             conv_done,
	output logic      [11:0] conv_result
);
	logic [1:0] cnt; // cycles since start
	logic       run; // conversion in flight
	// result is valid only with done; otherwise the inverse shows
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			run         <= 1'b0;
			cnt         <= 2'h0;
			conv_done   <= 1'b0;
			conv_result <= 12'hFFF;
		end else begin
			conv_done   <= 1'b0;
			conv_result <= ~level;
			if (conv_start) begin
				run <= 1'b1;
				cnt <= 2'h0;
			end else if (run) begin
				cnt <= cnt + 2'h1;
				if (cnt == 2'h2) begin
					run         <= 1'b0;
					conv_done   <= 1'b1;
					conv_result <= level;
				end
			end
		end
	end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "adcstc_consts.svh"
module tb_top;
	logic        ref_clk = 0, resetn = 0, reg_write = 0, reg_read = 0;
	logic [7:0]  reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, ev = 0, d;
	logic        conv_done, conv_start, scan_busy, irq;
	logic [11:0] conv_result, level = 0;
	logic [3:0]  conv_channel, chq[$];
	int          n_mismatch = 0, samples_checked = 0, n_start = 0;
	adcstc_top i_adcstc_top (.ref_clk(ref_clk), .resetn(resetn),
		.clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.trigger_events(ev), .conv_done(conv_done),
		.conv_result(conv_result), .conv_start(conv_start),
		.conv_channel(conv_channel), .scan_busy(scan_busy), .irq(irq));
	adcstc_conv_model i_adcstc_conv_model (.ref_clk(ref_clk),
		.resetn(resetn), .conv_start(conv_start), .level(level),
		.conv_done(conv_done), .conv_result(conv_result));
	initial forever #5 ref_clk = ~ref_clk;
	// log every start and its channel
	always @(posedge ref_clk) if (conv_start === 1'b1) begin
		n_start++;
		chq.push_back(conv_channel);
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_write <= 1; reg_addr <= a; reg_wdata <= v;
		@(posedge ref_clk);
		reg_write <= 0;
	endtask
	// data stand in the cycle after the strobe only
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		reg_read <= 1; reg_addr <= a;
		@(posedge ref_clk);
		reg_read <= 0;
		#1 v = reg_rdata;
	endtask
	task automatic run(input logic [31:0] sc);
		wr(`ADCSTC_OFF_SCAN, sc);
		chq.delete();
		wr(`ADCSTC_OFF_CTRL, 32'h1);
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 300 && scan_busy !== 1'b0; i++) @(posedge ref_clk);
	endtask
	task automatic t_regs();
		logic [7:0]  a[4] = '{`ADCSTC_OFF_HIGH, `ADCSTC_OFF_LOW,
			`ADCSTC_OFF_TRIG, `ADCSTC_OFF_SCAN};
		logic [31:0] m[4] = '{`ADCSTC_THR_MASK, `ADCSTC_THR_MASK,
			`ADCSTC_TRIG_MASK, `ADCSTC_SCAN_MASK};
		rd(a[0], d); chk("high rst", `ADCSTC_RST_HIGH, d);
		rd(a[1], d); chk("low rst", `ADCSTC_RST_LOW, d);
		rd(a[2], d); chk("trig rst", `ADCSTC_RST_TRIG, d);
		rd(a[3], d); chk("scan rst", `ADCSTC_RST_SCAN, d);
		// all ones written: only defined fields keep them
		for (int i = 0; i < 4; i++) begin
			wr(a[i], 32'hFFFF_FFFF);
			rd(a[i], d); chk("reg rw", m[i], d);
			wr(a[i], 32'h0);
		end
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C, d); chk("unmapped", 32'h0, d);
	endtask
	task automatic t_once();
		run(32'h0001_E001);
		chk("pass count", 4, chq.size());
		chk("ch a", 0, chq[0]);
		chk("ch b", 13, chq[1]);
		chk("ch c", 14, chq[2]);
		chk("ch d", 15, chq[3]);
	endtask
	task automatic t_cont();
		int n0;
		wr(`ADCSTC_OFF_SCAN, 32'h6);
		chq.delete();
		wr(`ADCSTC_OFF_CTRL, 32'h1);
		for (int i = 0; i < 300 && chq.size() < 5; i++) @(posedge ref_clk);
		for (int i = 0; i < 5; i++) chk("round ch", i % 2 + 1, chq[i]);
		wr(`ADCSTC_OFF_CTRL, 32'h0);
		repeat (20) @(posedge ref_clk);
		n0 = n_start;
		repeat (20) @(posedge ref_clk);
		chk("stopped", n0, n_start);
		chk("idle", 0, scan_busy);
	endtask
	task automatic t_trig();
		int n0;
		for (int b = 0; b < 32; b++) if (`ADCSTC_TRIG_MASK >> b & 1) begin
			// reserved bit 4 written as one must still not gate a start
			wr(`ADCSTC_OFF_TRIG, (32'h1 << b) | 32'h14);
			wr(`ADCSTC_OFF_SCAN, 32'h0001_0001);
			n0 = n_start;
			wr(`ADCSTC_OFF_CTRL, 32'h3);
			// every other real source but bit 2 fires while disabled
			ev <= (`ADCSTC_TRIG_MASK & ~((32'h1 << b) | 32'h4)) | 32'h10;
			repeat (10) @(posedge ref_clk);
			chk("masked src", n0, n_start);
			ev <= 32'h1 << b;
			repeat (12) @(posedge ref_clk);
			ev <= 0;
			repeat (10) @(posedge ref_clk);
			chk("enabled src", n0 + 1, n_start);
		end
		wr(`ADCSTC_OFF_TRIG, 32'h0);
	endtask
	task automatic t_wd();
		logic [11:0] lv[5] = '{12'h050, 12'h100, 12'h7FF, 12'h800, 12'hFFF};
		logic [2:0]  ex[5] = '{3'h1, 3'h4, 3'h4, 3'h2, 3'h2};
		wr(`ADCSTC_OFF_HIGH, 32'h800);
		wr(`ADCSTC_OFF_LOW, 32'h100);
		wr(`ADCSTC_OFF_IRQ_EN, 32'h1C);
		for (int i = 0; i < 5; i++) begin
			wr(`ADCSTC_OFF_IRQ_CLR, 32'h1F);
			level <= lv[i];
			run(32'h0001_0001);
			rd(`ADCSTC_OFF_IRQ_FLAG, d);
			chk("wd flags", {27'h0, ex[i], 2'h0}, d & 32'h1C);
			chk("irq on", 1, irq);
			rd(`ADCSTC_OFF_RESULT, d);
			chk("result", {20'h0, lv[i]}, d);
		end
		wr(`ADCSTC_OFF_IRQ_EN, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk("irq masked", 0, irq);
		wr(`ADCSTC_OFF_IRQ_EN, 32'h1C);
		repeat (2) @(posedge ref_clk);
		chk("irq unmask", 1, irq);
		wr(`ADCSTC_OFF_IRQ_CLR, 32'h1F);
		repeat (2) @(posedge ref_clk);
		chk("irq clear", 0, irq);
	endtask
	task automatic stop_test();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// watchdog far beyond the expected run length
	initial begin
		#300000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1;
		t_regs();
		t_once();
		t_cont();
		t_trig();
		t_wd();
		stop_test();
	end
endmodule
